// ==== shared/smcp_pkg.sv ====
// Shared constants for the setup-mode command parser link
package smcp_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int BAUD = 9600;
  localparam int BIT_CYCLES = CLK_HZ / BAUD;
  localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int LOW_TONE_HZ = 8000;
  localparam int HIGH_TONE_HZ = 16000;
  localparam int LOW_TONE_HALF = CLK_HZ / (2 * LOW_TONE_HZ);
  localparam int HIGH_TONE_HALF = CLK_HZ / (2 * HIGH_TONE_HZ);
  localparam int DATA_BITS = 8;
  localparam int CMD_MAX = 10;
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_TILDE = 8'h7e;
  localparam logic [7:0] CHAR_HASH = 8'h23;
  localparam logic [2:0] FACTORY_ADDR = 3'h0;
  localparam logic [3:0] FACTORY_CHAN = 4'h0;
  localparam int NV_WRITE_CYCLES = 1000;
  typedef enum logic [2:0] {
    SMCP_KEY_OFF = 3'b000,
    SMCP_KEY_CARRIER = 3'b001,
    SMCP_KEY_LOW = 3'b010,
    SMCP_KEY_HIGH = 3'b011,
    SMCP_KEY_PACKET = 3'b100
  } smcp_key_t;
endpackage

// ==== shared/smcp_link_if.sv ====
// Serial link and strap between host and modem controller
`timescale 1ns/1ps
interface smcp_link_if;
  logic setupN;
  logic hostSerialIn;
  logic hostSerialOut;
  logic busy;
  modport device (input setupN, input hostSerialIn, output hostSerialOut, output busy);
  modport host (output setupN, output hostSerialIn, input hostSerialOut, input busy);
endinterface

// ==== verilog/smcp_host.sv ====
// Host end: drives setup strap, sends bytes, returns received bytes
`timescale 1ns/1ps
module smcp_host #(
  parameter int BIT_CYCLES = smcp_pkg::BIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  smcp_link_if.host link,
  input wire logic setupReq,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic txReady,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic busySeen
);
  logic [15:0] txCnt;
  logic [3:0] txBit;
  logic [9:0] txShift;
  logic txActive;
  logic [1:0] rxSync;
  logic [1:0] busySync;
  logic [15:0] rxCnt;
  logic [3:0] rxBit;
  logic [7:0] rxShift;
  logic rxActive;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.setupN <= 1'b1;
    end else begin
      link.setupN <= ~setupReq;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busySync <= 2'h0;
      busySeen <= 1'b0;
    end else begin
      busySync <= {busySync[0], link.busy};
      busySeen <= busySync[1];
    end
  end

  // start, 8 data, stop; caller supplies CR on txData like any byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txActive <= 1'b0;
      txCnt <= 16'h0;
      txBit <= 4'h0;
      txShift <= 10'h3ff;
      link.hostSerialIn <= 1'b1;
      txReady <= 1'b0;
    end else if (!txActive) begin
      txReady <= 1'b1;
      link.hostSerialIn <= 1'b1;
      if (txValid && txReady) begin
        txActive <= 1'b1;
        txReady <= 1'b0;
        txShift <= {1'b1, txData, 1'b0};
        txCnt <= 16'h0;
        txBit <= 4'h0;
      end
    end else begin
      link.hostSerialIn <= txShift[0];
      if (txCnt == 16'(BIT_CYCLES - 1)) begin
        txCnt <= 16'h0;
        txShift <= {1'b1, txShift[9:1]};
        if (txBit == 4'h9) begin
          txActive <= 1'b0;
        end
        txBit <= txBit + 4'h1;
      end else begin
        txCnt <= txCnt + 16'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxSync <= 2'h3;
      rxActive <= 1'b0;
      rxCnt <= 16'h0;
      rxBit <= 4'h0;
      rxShift <= 8'h0;
      rxValid <= 1'b0;
      rxData <= 8'h0;
    end else begin
      rxSync <= {rxSync[0], link.hostSerialOut};
      rxValid <= 1'b0;
      if (!rxActive) begin
        if (!rxSync[1]) begin
          rxActive <= 1'b1;
          rxCnt <= 16'h0;
          rxBit <= 4'h0;
        end
      end else if (rxCnt == 16'(rxBit == 4'h0 ? BIT_CYCLES / 2 - 1 : BIT_CYCLES - 1)) begin
        rxCnt <= 16'h0;
        rxBit <= rxBit + 4'h1;
        if (rxBit == 4'h0 && rxSync[1]) begin
          rxActive <= 1'b0;
        end else if (rxBit == 4'h9) begin
          rxActive <= 1'b0;
          if (rxSync[1]) begin
            rxValid <= 1'b1;
            rxData <= rxShift;
          end
        end else if (rxBit != 4'h0) begin
          rxShift <= {rxSync[1], rxShift[7:1]};
        end
      end else begin
        rxCnt <= rxCnt + 16'h1;
      end
    end
  end
endmodule // smcp_host

// ==== verilog/smcp_device.sv ====
// Device end: setup-mode command interpreter with serial echo
// Contract
// - Setup strap low selects command mode
// - Radio link disabled during setup mode
// - Echo every received character in setup
// - 8N1 at 9600, one or two stops
// - Only defined command strings take effect
// - Set-address digit 0-7 selects address
// - Radio traffic only with matching address
// - Volatile address loaded from nonvolatile default
// - Store command writes address and channel
// - Tilde sent when nonvolatile write ends
// - Carrier, 8k, 16k tones; hash stops
// - Commands execute only on carriage return
// - Strap high resumes normal radio operation
// - Busy only warns, never throttles host
// - Busy high while receive buffer valid
// - Transmit enable low while keying transmitter
`timescale 1ns/1ps
module smcp_device #(
  parameter int NV_WRITE_CYCLES = smcp_pkg::NV_WRITE_CYCLES,
  parameter int BIT_CYCLES = smcp_pkg::BIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  smcp_link_if.device link,
  input wire logic radioRxValid,
  input wire logic [2:0] radioRxAddr,
  input wire logic radioTxReq,
  output logic radioTxEnableN,
  output logic radioRxEnableN,
  output logic radioTxData,
  output logic [2:0] linkAddr,
  output logic setupActive,
  output logic nvWrite,
  output logic [2:0] nvAddr,
  output logic [3:0] nvChan
);
  logic [1:0] setupSync;
  logic [1:0] rxSync;
  logic rxActive;
  logic [15:0] rxCnt;
  logic [3:0] rxBit;
  logic [7:0] rxShift;
  logic rxStrobe;
  logic [7:0] rxByte;
  logic [7:0] cmdBuf [smcp_pkg::CMD_MAX];
  logic [3:0] cmdLen;
  logic [3:0] curChan;
  logic nvLoaded;
  logic [15:0] nvCnt;
  logic nvBusy;
  logic tildeReq;
  logic tildePend;
  logic txActive;
  logic [15:0] txCnt;
  logic [3:0] txBit;
  logic [9:0] txShift;
  logic echoPend;
  logic [7:0] echoByte;
  smcp_pkg::smcp_key_t keyMode;
  logic [15:0] toneCnt;
  logic busyOut;

  function automatic logic cmdIs(input logic [7:0] s [smcp_pkg::CMD_MAX], input logic [3:0] n,
                                 input logic [79:0] word, input logic [3:0] len);
    logic ok;
    ok = (n == len);
    for (int i = 0; i < smcp_pkg::CMD_MAX; i++) begin
      if (i < len && s[i] != word[8*(len-1-i) +: 8]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      setupSync <= 2'h3;
      setupActive <= 1'b0;
    end else begin
      setupSync <= {setupSync[0], link.setupN};
      setupActive <= ~setupSync[1];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxSync <= 2'h3;
      rxActive <= 1'b0;
      rxCnt <= 16'h0;
      rxBit <= 4'h0;
      rxShift <= 8'h0;
      rxStrobe <= 1'b0;
      rxByte <= 8'h0;
    end else begin
      rxSync <= {rxSync[0], link.hostSerialIn};
      rxStrobe <= 1'b0;
      if (!rxActive) begin
        if (!rxSync[1]) begin
          rxActive <= 1'b1;
          rxCnt <= 16'h0;
          rxBit <= 4'h0;
        end
      end else if (rxCnt == 16'(rxBit == 4'h0 ? BIT_CYCLES / 2 - 1 : BIT_CYCLES - 1)) begin
        rxCnt <= 16'h0;
        rxBit <= rxBit + 4'h1;
        if (rxBit == 4'h0 && rxSync[1]) begin
          rxActive <= 1'b0;
        end else if (rxBit == 4'h9) begin
          rxActive <= 1'b0;
          rxStrobe <= rxSync[1] & setupActive;
          rxByte <= rxShift;
        end else if (rxBit != 4'h0) begin
          rxShift <= {rxSync[1], rxShift[7:1]};
        end
      end else begin
        rxCnt <= rxCnt + 16'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmdLen <= 4'h0;
      for (int i = 0; i < smcp_pkg::CMD_MAX; i++) begin
        cmdBuf[i] <= 8'h0;
      end
    end else if (!setupActive) begin
      cmdLen <= 4'h0;
    end else if (rxStrobe) begin
      if (rxByte == smcp_pkg::CHAR_CR) begin
        cmdLen <= 4'h0;
      end else if (cmdLen < 4'(smcp_pkg::CMD_MAX)) begin
        cmdBuf[cmdLen] <= rxByte;
        cmdLen <= cmdLen + 4'h1;
      end else begin
        cmdLen <= 4'(smcp_pkg::CMD_MAX + 1);
      end
    end
  end

  wire execNow = rxStrobe && setupActive && rxByte == smcp_pkg::CHAR_CR;
  wire addrCmd = cmdLen == 4'h5 && cmdIs(cmdBuf, 4'h4, 80'h41444452, 4'h4)
                 && cmdBuf[4] >= 8'h30 && cmdBuf[4] <= 8'h37;

  // load defaults once after reset; set address; others ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      linkAddr <= smcp_pkg::FACTORY_ADDR;
      curChan <= smcp_pkg::FACTORY_CHAN;
      nvLoaded <= 1'b0;
    end else if (!nvLoaded) begin
      linkAddr <= nvAddr;
      curChan <= nvChan;
      nvLoaded <= 1'b1;
    end else if (execNow && addrCmd) begin
      linkAddr <= cmdBuf[4][2:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nvAddr <= smcp_pkg::FACTORY_ADDR;
      nvChan <= smcp_pkg::FACTORY_CHAN;
      nvWrite <= 1'b0;
      nvBusy <= 1'b0;
      nvCnt <= 16'h0;
      tildeReq <= 1'b0;
    end else begin
      tildeReq <= 1'b0;
      if (!nvBusy && execNow &&
          cmdIs(cmdBuf, cmdLen, 80'h53455450524f4752414d, 4'ha)) begin
        nvBusy <= 1'b1;
        nvWrite <= 1'b1;
        nvCnt <= 16'h0;
        nvAddr <= linkAddr;
        nvChan <= curChan;
      end else if (nvBusy) begin
        if (nvCnt == 16'(NV_WRITE_CYCLES - 1)) begin
          nvBusy <= 1'b0;
          nvWrite <= 1'b0;
          tildeReq <= 1'b1;
        end else begin
          nvCnt <= nvCnt + 16'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      keyMode <= smcp_pkg::SMCP_KEY_OFF;
    end else if (!setupActive) begin
      keyMode <= radioTxReq ? smcp_pkg::SMCP_KEY_PACKET : smcp_pkg::SMCP_KEY_OFF;
    end else if (keyMode == smcp_pkg::SMCP_KEY_PACKET) begin
      keyMode <= smcp_pkg::SMCP_KEY_OFF;
    end else if (execNow) begin
      if (cmdIs(cmdBuf, cmdLen, 80'h4e4f544f4e45, 4'h6)) begin
        keyMode <= smcp_pkg::SMCP_KEY_CARRIER;
      end else if (cmdIs(cmdBuf, cmdLen, 80'h4c46544f4e45, 4'h6)) begin
        keyMode <= smcp_pkg::SMCP_KEY_LOW;
      end else if (cmdIs(cmdBuf, cmdLen, 80'h4846544f4e45, 4'h6)) begin
        keyMode <= smcp_pkg::SMCP_KEY_HIGH;
      end else if (cmdIs(cmdBuf, cmdLen, {72'h0, smcp_pkg::CHAR_HASH}, 4'h1)) begin
        keyMode <= smcp_pkg::SMCP_KEY_OFF;
      end
    end
  end

  // keyed output and tones; no packets in setup
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      radioTxEnableN <= 1'b1;
      radioRxEnableN <= 1'b1;
      radioTxData <= 1'b0;
      toneCnt <= 16'h0;
    end else begin
      radioTxEnableN <= keyMode == smcp_pkg::SMCP_KEY_OFF;
      radioRxEnableN <= setupActive;
      case (keyMode)
        smcp_pkg::SMCP_KEY_LOW, smcp_pkg::SMCP_KEY_HIGH, smcp_pkg::SMCP_KEY_PACKET: begin
          if (toneCnt >= 16'(keyMode == smcp_pkg::SMCP_KEY_HIGH ?
                             smcp_pkg::HIGH_TONE_HALF - 1 : smcp_pkg::LOW_TONE_HALF - 1)) begin
            toneCnt <= 16'h0;
            radioTxData <= ~radioTxData;
          end else begin
            toneCnt <= toneCnt + 16'h1;
          end
        end
        smcp_pkg::SMCP_KEY_CARRIER: begin
          radioTxData <= 1'b1;
          toneCnt <= 16'h0;
        end
        default: begin
          radioTxData <= 1'b0;
          toneCnt <= 16'h0;
        end
      endcase
    end
  end

  // accept only matching address; busy on valid data; no throttle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyOut <= 1'b0;
      link.busy <= 1'b0;
    end else begin
      busyOut <= !setupActive && radioRxValid && radioRxAddr == linkAddr;
      link.busy <= busyOut;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      echoPend <= 1'b0;
      echoByte <= 8'h0;
      tildePend <= 1'b0;
      txActive <= 1'b0;
      txCnt <= 16'h0;
      txBit <= 4'h0;
      txShift <= 10'h3ff;
      link.hostSerialOut <= 1'b1;
    end else begin
      if (rxStrobe) begin
        echoPend <= 1'b1;
        echoByte <= rxByte;
      end
      // tilde held until line is free
      if (tildeReq) begin
        tildePend <= 1'b1;
      end
      if (!txActive) begin
        link.hostSerialOut <= 1'b1;
        if (echoPend || tildePend) begin
          txActive <= 1'b1;
          txCnt <= 16'h0;
          txBit <= 4'h0;
          txShift <= {1'b1, echoPend ? echoByte : smcp_pkg::CHAR_TILDE, 1'b0};
          if (echoPend && !rxStrobe) begin
            echoPend <= 1'b0;
          end else if (!echoPend && !tildeReq) begin
            tildePend <= 1'b0;
          end
        end
      end else begin
        link.hostSerialOut <= txShift[0];
        if (txCnt == 16'(BIT_CYCLES - 1)) begin
          txCnt <= 16'h0;
          txShift <= {1'b1, txShift[9:1]};
          txBit <= txBit + 4'h1;
          if (txBit == 4'h9) begin
            txActive <= 1'b0;
          end
        end else begin
          txCnt <= txCnt + 16'h1;
        end
      end
    end
  end
endmodule // smcp_device

// ==== sim/smcp_link_monitor.sv ====
// Serial link and strap checker between host and device ends
`timescale 1ns/1ps
module smcp_link_monitor #(
  parameter int BIT_CYCLES = smcp_pkg::BIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic setupN,
  input wire logic hostSerialIn,
  input wire logic hostSerialOut,
  input wire logic busy
);
  localparam int BIT = BIT_CYCLES;
  localparam int FRAME = 10 * BIT;
  int outCnt;
  int inCnt;
  int pendCnt;
  int sinceSetup;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Position within a device frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) outCnt <= 0;
    else if (outCnt == FRAME - 1) outCnt <= 0;
    else if (outCnt != 0 || !hostSerialOut) outCnt <= outCnt + 1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) inCnt <= 0;
    else if (inCnt == FRAME - 1) inCnt <= 0;
    else if (inCnt != 0 || !hostSerialIn) inCnt <= inCnt + 1;
  end
  // Wait from a host character to its echo
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pendCnt <= 0;
    else if (pendCnt == 0) pendCnt <= (inCnt == 0 && !hostSerialIn && !setupN) ? 1 : 0;
    else if (outCnt == 0 && !hostSerialOut && pendCnt >= 9 * BIT) pendCnt <= 0;
    else pendCnt <= pendCnt + 1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) sinceSetup <= 3 * FRAME;
    else if (!setupN) sinceSetup <= 0;
    else if (sinceSetup < 3 * FRAME) sinceSetup <= sinceSetup + 1;
  end
  out_start_bit_a: assert property (outCnt >= 1 && outCnt <= BIT - 3 |-> !hostSerialOut)
    else $error("device start bit not held low");
  out_stop_bit_a: assert property (outCnt >= 9 * BIT + 3 && outCnt <= FRAME - 3 |-> hostSerialOut)
    else $error("device stop bit not high");
  out_bit_stable_a: assert property (outCnt != 0 && outCnt % BIT >= 3 && outCnt % BIT <= BIT - 3
    |-> $stable(hostSerialOut)) else $error("device bit changed mid cell");
  host_start_bit_a: assert property (inCnt >= 1 && inCnt <= BIT - 3 |-> !hostSerialIn)
    else $error("host start bit not held low");
  host_stop_bit_a: assert property (inCnt >= 9 * BIT + 3 && inCnt <= FRAME - 3 |-> hostSerialIn)
    else $error("host stop bit not high");
  echo_latency_a: assert property (pendCnt <= 12 * BIT)
    else $error("echo not started in time");
  echo_in_setup_a: assert property (outCnt == 0 && !hostSerialOut |-> sinceSetup < 3 * FRAME)
    else $error("serial output outside setup");
  busy_in_setup_a: assert property (!setupN [*6] |-> !busy)
    else $error("busy raised during setup");
  cover property (outCnt == FRAME - 1);
  cover property (pendCnt >= 9 * BIT && outCnt == 0 && !hostSerialOut);
  cover property ($rose(busy));
endmodule // smcp_link_monitor

// ==== sim/setup_mode_command_parser_tb.sv ====
// Self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checkCount++; if ((got) !== (ex)) begin numErrors++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module setup_mode_command_parser_tb;
  localparam int BIT = 32;
  localparam int FRAME = 10 * BIT;
  localparam int NV_CYC = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic setupReq = 1'b0;
  logic txValid = 1'b0;
  logic radioRxValid = 1'b0;
  logic radioTxReq = 1'b0;
  logic [7:0] txData = 8'h00;
  logic [2:0] radioRxAddr = 3'h0;
  logic txReady, rxValid, busySeen, radioTxEnableN, radioRxEnableN, radioTxData;
  logic setupActive, nvWrite;
  logic [7:0] rxData;
  logic [2:0] linkAddr, nvAddr;
  logic [3:0] nvChan;
  logic [7:0] rxq[$];
  logic [7:0] expq[$];
  int numErrors = 0;
  int checkCount = 0;
  int n;
  int nvHigh = 0;
  string toneCmd[3] = '{{"NO", "TONE"}, {"LF", "TONE"}, {"HF", "TONE"}};
  int toneHalf[3] = '{0, smcp_pkg::LOW_TONE_HALF, smcp_pkg::HIGH_TONE_HALF};
  smcp_link_if linkIf();
  smcp_host #(.BIT_CYCLES(BIT)) i_smcp_host (.clk(clk), .rst(rst), .link(linkIf),
    .setupReq(setupReq), .txValid(txValid), .txData(txData), .txReady(txReady),
    .rxValid(rxValid), .rxData(rxData), .busySeen(busySeen));
  smcp_device #(.NV_WRITE_CYCLES(NV_CYC), .BIT_CYCLES(BIT)) i_smcp_device (.clk(clk),
    .rst(rst), .link(linkIf), .radioRxValid(radioRxValid), .radioRxAddr(radioRxAddr),
    .radioTxReq(radioTxReq),
    .radioTxEnableN(radioTxEnableN), .radioRxEnableN(radioRxEnableN),
    .radioTxData(radioTxData), .linkAddr(linkAddr), .setupActive(setupActive),
    .nvWrite(nvWrite), .nvAddr(nvAddr), .nvChan(nvChan));
  smcp_link_monitor #(.BIT_CYCLES(BIT)) i_smcp_link_monitor (.clk(clk), .rst(rst),
    .setupN(linkIf.setupN), .hostSerialIn(linkIf.hostSerialIn),
    .hostSerialOut(linkIf.hostSerialOut), .busy(linkIf.busy));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (rxValid === 1'b1) rxq.push_back(rxData);
  // Cycles spent in the nonvolatile write
  always @(posedge clk) if (nvWrite === 1'b1) nvHigh++;
  task automatic completeRun;
    $display("errors %0d checks %0d", numErrors, checkCount);
    if (numErrors == 0 && checkCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic timedOut(input string nm);
    numErrors++;
    $display("wrong value %s expected done seen timeout", nm);
    completeRun;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  // Hold the byte until the host end takes it
  task automatic sendByte(input logic [7:0] b);
    int i;
    i = 0;
    txValid <= 1'b1;
    txData <= b;
    do begin @(posedge clk); i++; end while (txReady !== 1'b1 && i < 2 * FRAME);
    if (txReady !== 1'b1) timedOut("txReady");
    txValid <= 1'b0;
    expq.push_back(b);
    @(posedge clk);
  endtask
  task automatic sendCmd(input string s, input bit cr);
    for (int i = 0; i < s.len(); i++) sendByte(s[i]);
    if (cr) sendByte(smcp_pkg::CHAR_CR);
  endtask
  task automatic waitEcho;
    int i;
    i = 0;
    while (rxq.size() < expq.size() && i < 4 * FRAME) begin @(posedge clk); i++; end
    if (rxq.size() < expq.size()) timedOut("echo");
  endtask
  // Cycles between two changes of the baseband output
  task automatic halfPeriod(output int c);
    logic v;
    for (int k = 0; k < 2; k++) begin
      c = 0;
      v = radioTxData;
      while (radioTxData === v && c < 4000) begin @(posedge clk); c++; end
    end
  endtask
  initial begin
    tick(12);
    rst <= 1'b0;
    radioRxValid <= 1'b1;
    tick(5);
    `CHK("linkAddr", smcp_pkg::FACTORY_ADDR, linkAddr)
    `CHK("busy", 1'b1, linkIf.busy)
    radioRxAddr <= 3'h2;
    radioTxReq <= 1'b1;
    tick(5);
    `CHK("busy", 1'b0, linkIf.busy)
    `CHK("radioTxEnableN", 1'b0, radioTxEnableN)
    setupReq <= 1'b1;
    radioRxAddr <= 3'h0;
    tick(10);
    `CHK("setupActive", 1'b1, setupActive)
    `CHK("radioRxEnableN", 1'b1, radioRxEnableN)
    `CHK("radioTxEnableN", 1'b1, radioTxEnableN)
    `CHK("busy", 1'b0, linkIf.busy)
    sendCmd("ADDR7", 1'b0);
    tick(6000);
    `CHK("linkAddr", smcp_pkg::FACTORY_ADDR, linkAddr)
    sendCmd("", 1'b1);
    waitEcho;
    `CHK("linkAddr", 3'h7, linkAddr)
    sendCmd("ADDR9", 1'b1);
    waitEcho;
    `CHK("linkAddr", 3'h7, linkAddr)
    sendCmd({"SET", "PROGRAM"}, 1'b1);
    expq.push_back(smcp_pkg::CHAR_TILDE);
    waitEcho;
    `CHK("nvAddr", 3'h7, nvAddr)
    `CHK("nvChan", smcp_pkg::FACTORY_CHAN, nvChan)
    `CHK("nvWriteCycles", NV_CYC, nvHigh)
    for (int k = 0; k < 3; k++) begin
      sendCmd(toneCmd[k], 1'b1);
      waitEcho;
      `CHK("radioTxEnableN", 1'b0, radioTxEnableN)
      if (k == 0) `CHK("radioTxData", 1'b1, radioTxData)
      else begin
        halfPeriod(n);
        `CHK("toneHalf", toneHalf[k], n)
      end
    end
    sendCmd("#", 1'b1);
    waitEcho;
    `CHK("radioTxEnableN", 1'b1, radioTxEnableN)
    setupReq <= 1'b0;
    radioRxAddr <= 3'h7;
    tick(10);
    `CHK("setupActive", 1'b0, setupActive)
    `CHK("radioRxEnableN", 1'b0, radioRxEnableN)
    `CHK("busy", 1'b1, linkIf.busy)
    `CHK("busySeen", 1'b1, busySeen)
    `CHK("radioTxEnableN", 1'b0, radioTxEnableN)
    `CHK("echoCount", expq.size(), rxq.size())
    for (int i = 0; i < expq.size() && i < rxq.size(); i++) `CHK("echo", expq[i], rxq[i])
    completeRun;
  end
endmodule // setup_mode_command_parser_tb
